// *** asc_pkg.sv ***
// Package for the static memory access controller.
// Assumes a 20 MHz system clock; all pin timings are expressed as cycle counts.
package asc_pkg;
  localparam int CLK_PERIOD_PS = 50000;
  // Speed-grade figures in picoseconds
  localparam int T_RC_FAST_PS = 45000;
  localparam int T_RC_SLOW_PS = 55000;
  localparam int T_AA_FAST_PS = 45000;
  localparam int T_AA_SLOW_PS = 55000;
  localparam int T_DOE_FAST_PS = 22000;
  localparam int T_DOE_SLOW_PS = 25000;
  localparam int T_PWE_FAST_PS = 35000;
  localparam int T_PWE_SLOW_PS = 40000;
  localparam int T_SD_PS = 25000;
  localparam int T_HZWE_FAST_PS = 18000;
  localparam int T_HZWE_SLOW_PS = 20000;
  localparam int T_HZOE_PS = 18000;
  localparam int T_HD_PS = 0;

  localparam int CNT_W = 4;

  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // Least cycle counts, slow grade covers both
  localparam logic [CNT_W-1:0] CYC_RC = CNT_W'(cyc_min(T_RC_SLOW_PS));
  localparam logic [CNT_W-1:0] CYC_READ = CNT_W'(cyc_min(T_AA_SLOW_PS));
  localparam logic [CNT_W-1:0] CYC_WPULSE =
    CNT_W'(cyc_min((T_PWE_SLOW_PS > T_HZWE_SLOW_PS + T_SD_PS) ?
                   T_PWE_SLOW_PS : T_HZWE_SLOW_PS + T_SD_PS));
  localparam logic [CNT_W-1:0] CYC_TURN = CNT_W'(cyc_min(T_HZOE_PS));
  localparam logic [CNT_W-1:0] CYC_HOLD = CNT_W'(cyc_min(T_HD_PS));

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_n;
  } asc_req_t;

  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic write_n;
    logic output_n;
    logic upper_lane_n;
    logic lower_lane_n;
  } asc_ctl_t;

  localparam asc_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : asc_pkg

// *** asc_sync.sv ***
// Three-stage synchroniser with second/third agreement filter.
// Assumes an asynchronous pin input and a single clock.
`timescale 1ns/1ps
module asc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset
  input wire logic [W-1:0] din, // Asynchronous input
  output logic [W-1:0] dout // Filtered value
);
  logic [W-1:0] s1, s2, s3, next_dout;
  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : asc_sync

// *** asc_ctrl.sv ***
// Host controller driving an asynchronous static memory with error flag.
// Assumes the memory pins are wired directly; bus wire resolved outside.
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ADDR_WIDTH = asc_pkg::ADDR_W,
  parameter int DATA_WIDTH = asc_pkg::DATA_W
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // Async active-low reset
  input wire asc_pkg::asc_req_t req, // Request fields
  input wire logic req_valid, // Request offered
  output logic req_ready, // Request taken this cycle
  input wire logic retain_req, // Ask to enter retention
  output logic retain_ok, // Memory deselected, safe
  output logic [DATA_WIDTH-1:0] rdata, // Read data
  output logic rerr, // Read error flag
  output logic rvalid, // Read result pulse
  output logic wdone, // Write done pulse
  output asc_pkg::asc_ctl_t mem_ctl, // Memory strobes
  output logic [ADDR_WIDTH-1:0] mem_addr, // Memory address
  output logic [DATA_WIDTH-1:0] mem_dq_out, // Data to memory
  output logic mem_dq_oe_n, // Low while driving data
  input wire logic [DATA_WIDTH-1:0] mem_dq_in, // Data from memory
  input wire logic mem_err // Error flag from memory
);
  import asc_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_RD, S_TURN, S_WR, S_HOLD, S_GAP, S_RET
  } asc_state_t;

  // Two-flop release so all state leaves reset on one edge
  logic rst_a, rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // Read data and error flag arrive asynchronously
  logic [DATA_WIDTH:0] pin_sync;
  asc_sync #(.W(DATA_WIDTH + 1)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({mem_err, mem_dq_in}),
    .dout(pin_sync)
  );

  asc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, cyc, next_cyc;
  asc_ctl_t next_ctl;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [DATA_WIDTH-1:0] next_dq, next_rdata;
  logic next_oe_n, next_rerr, next_rvalid, next_wdone;

  // Three sync stages plus the agreement register before the pin value is usable
  localparam logic [CNT_W-1:0] SYNC_LAT = 4'h4;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;

  // True on the last cycle of a countdown
  function automatic logic cnt_last(input logic [CNT_W-1:0] c);
    return c <= CNT_LAST;
  endfunction : cnt_last

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cyc = (cyc != '0) ? cyc - 1'b1 : cyc;
    next_ctl = mem_ctl;
    next_addr = mem_addr;
    next_dq = mem_dq_out;
    next_oe_n = mem_dq_oe_n;
    next_rdata = rdata;
    next_rerr = rerr;
    next_rvalid = 1'b0;
    next_wdone = 1'b0;
    req_ready = 1'b0;
    unique case (state)
      S_IDLE: begin
        // Retention wins over a waiting request
        if (retain_req) begin
          next_ctl = CTL_IDLE;
          next_state = S_RET;
        end else if (req_valid && cyc == '0) begin
          req_ready = 1'b1;
          next_addr = req.addr[ADDR_WIDTH-1:0];
          next_ctl.select_low_n = 1'b0;
          next_ctl.select_high = 1'b1;
          next_ctl.upper_lane_n = req.lane_n[1];
          next_ctl.lower_lane_n = req.lane_n[0];
          next_cyc = CYC_RC;
          if (req.write) begin
            next_dq = req.wdata[DATA_WIDTH-1:0];
            next_cnt = CYC_TURN;
            next_state = S_TURN;
          end else begin
            next_ctl.output_n = 1'b0;
            next_cnt = CYC_READ + SYNC_LAT;
            next_state = S_RD;
          end
        end
      end
      S_RD: begin
        if (cnt_last(cnt)) begin
          next_rdata = pin_sync[DATA_WIDTH-1:0];
          next_rerr = pin_sync[DATA_WIDTH];
          next_rvalid = 1'b1;
          next_ctl = CTL_IDLE;
          next_cnt = CYC_TURN;
          next_state = S_GAP;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_TURN: begin
        // Device outputs are already off; wait their float time first
        if (cnt_last(cnt)) begin
          next_oe_n = 1'b0;
          next_ctl.write_n = 1'b0;
          next_cnt = CYC_WPULSE;
          next_state = S_WR;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_WR: begin
        if (cnt_last(cnt)) begin
          next_ctl.write_n = 1'b1;
          next_cnt = CYC_HOLD;
          next_state = S_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_HOLD: begin
        // Address, data, selects held one cycle past the ending edge
        next_oe_n = 1'b1;
        next_ctl = CTL_IDLE;
        next_wdone = 1'b1;
        next_cnt = CYC_TURN;
        next_state = S_GAP;
      end
      S_GAP: begin
        // Bus turn-around before the next cycle
        if (cnt_last(cnt)) begin
          next_state = S_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_RET: begin
        // Memory stays deselected until released
        if (!retain_req) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  assign retain_ok = (state == S_RET);

  // Pin outputs registered so strobes cannot glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      cyc <= '0;
      mem_ctl <= CTL_IDLE;
      mem_addr <= '0;
      mem_dq_out <= '0;
      mem_dq_oe_n <= 1'b1;
      rdata <= '0;
      rerr <= 1'b0;
      rvalid <= 1'b0;
      wdone <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cyc <= next_cyc;
      mem_ctl <= next_ctl;
      mem_addr <= next_addr;
      mem_dq_out <= next_dq;
      mem_dq_oe_n <= next_oe_n;
      rdata <= next_rdata;
      rerr <= next_rerr;
      rvalid <= next_rvalid;
      wdone <= next_wdone;
    end
  end
endmodule : asc_ctrl

// *** asc_monitor.sv ***
// Checker on the memory pin sequencing of the static memory controller.
// Assumes binding to asc_ctrl and sight of its ports only.
`timescale 1ns/1ps
module asc_monitor
  import asc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic req_valid, // Offered
  input wire logic req_ready, // Taken
  input wire logic retain_ok, // Retention
  input wire logic rvalid, // Read pulse
  input wire logic wdone, // Write pulse
  input wire asc_pkg::asc_ctl_t mem_ctl, // Strobes
  input wire logic [ADDR_W-1:0] mem_addr, // Address
  input wire logic [DATA_W-1:0] mem_dq_out, // Write data
  input wire logic mem_dq_oe_n // Drive enable
);
  logic sel;
  logic lane;
  assign sel = !mem_ctl.select_low_n && mem_ctl.select_high;
  assign lane = !(mem_ctl.upper_lane_n && mem_ctl.lower_lane_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_low;
    !mem_ctl.write_n [*1];
  endsequence
  sequence wr_end;
    mem_ctl.write_n && $stable(mem_addr) && $stable(mem_dq_out) && !mem_dq_oe_n;
  endsequence
  wpulse_len_a: assert property ($fell(mem_ctl.write_n) |-> wr_low ##1 wr_end)
    else $error("write pulse or hold wrong");
  wr_qual_a: assert property (!mem_ctl.write_n |-> sel && lane && !mem_dq_oe_n)
    else $error("write without qualifiers");
  wr_setup_a: assert property ($fell(mem_ctl.write_n) |-> $stable(mem_addr) && $past(sel))
    else $error("address or selects late");
  wdone_a: assert property ($rose(mem_ctl.write_n) |=> wdone && mem_ctl == CTL_IDLE)
    else $error("write end wrong");
  bus_turn_a: assert property (!mem_dq_oe_n |-> mem_ctl.output_n)
    else $error("bus driven while memory outputs on");
  retain_desel_a: assert property (retain_ok |-> mem_ctl == CTL_IDLE)
    else $error("retention while selected");
  cycle_gap_a: assert property (req_valid && req_ready |=> !req_ready [*2])
    else $error("cycles too close");
  read_lat_a: assert property ($fell(mem_ctl.output_n) |-> ##6 rvalid)
    else $error("read result late");
endmodule : asc_monitor
bind asc_ctrl asc_monitor i_asc_monitor (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
  .req_ready(req_ready), .retain_ok(retain_ok), .rvalid(rvalid), .wdone(wdone),
  .mem_ctl(mem_ctl), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n));

// *** asc_mem_model.sv ***
// Behavioural static memory of sixteen words with error flag on odd words.
// Assumes the controller pins wired directly; resolves the shared data bus.
`timescale 1ns/1ps
module asc_mem_model
  import asc_pkg::*;
(
  input wire asc_pkg::asc_ctl_t ctl, // Strobes
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic [DATA_W-1:0] dq_out, // Controller data
  input wire logic dq_oe_n, // Controller drives when low
  output logic [DATA_W-1:0] dq_in, // Resolved bus
  output logic err // Error flag
);
  logic [15:0] mem [16] = '{default: 16'h0000};
  logic [15:0] drv = 16'h0000;
  logic rd;
  initial err = 1'b0;
  assign dq_in = !dq_oe_n ? dq_out : drv;
  always @(ctl, addr, dq_out) begin
    rd = !ctl.select_low_n && ctl.select_high && ctl.write_n && !ctl.output_n;
    if (!ctl.select_low_n && ctl.select_high && !ctl.write_n) begin
      if (!ctl.upper_lane_n) mem[addr[3:0]][15:8] = dq_out[15:8];
      if (!ctl.lower_lane_n) mem[addr[3:0]][7:0] = dq_out[7:0];
    end
    drv <= #10 ~drv;
    drv <= #55 rd ? mem[addr[3:0]] : ~drv;
    err <= #55 rd & addr[0];
  end
endmodule : asc_mem_model

// *** tb.sv ***
// Self-checking bench for the static memory controller.
// Assumes the behavioural memory model and the bound checker.
`timescale 1ns/1ps
module tb;
  import asc_pkg::*;
  logic clk = 0, reset_n = 0, req_valid = 0, retain_req = 0;
  asc_req_t req = '0;
  logic req_ready, retain_ok, rerr, rvalid, wdone, dq_oe_n, err;
  logic [15:0] rdata, dq_out, dq_in;
  logic [19:0] addr;
  asc_ctl_t ctl;
  logic [15:0] shadow [16];
  logic [16:0] expq [$];
  logic [35:0] wq [$];
  logic [31:0] seed = 32'h0000_02c7;
  int err_count = 0;
  int compares = 0;
  always #25 clk = ~clk;
  asc_ctrl i_asc_ctrl (.clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .retain_req(retain_req), .retain_ok(retain_ok), .rdata(rdata),
    .rerr(rerr), .rvalid(rvalid), .wdone(wdone), .mem_ctl(ctl), .mem_addr(addr),
    .mem_dq_out(dq_out), .mem_dq_oe_n(dq_oe_n), .mem_dq_in(dq_in), .mem_err(err));
  asc_mem_model i_asc_mem_model (.ctl(ctl), .addr(addr), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in), .err(err));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chk_w(input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_w
  task automatic results();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] ln);
    int i;
    @(posedge clk);
    req <= '{w, {16'h0000, a}, d, ln};
    req_valid <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (!req_ready && i < 40);
    if (!req_ready) begin
      err_count++;
      results();
    end
    if (w && !ln[1]) shadow[a][15:8] = d[15:8];
    if (w && !ln[0]) shadow[a][7:0] = d[7:0];
    if (!w) expq.push_back({a[0], shadow[a]});
    if (w) wq.push_back({16'h0000, a, d});
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : op
  always @(posedge clk) if (rvalid) chk(expq.pop_front(), {rerr, rdata});
  always @(posedge clk) if (wdone) chk_w(wq.pop_front(), {addr, dq_out});
  initial begin
    int k;
    logic [31:0] v;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 16; k++) op(1'b1, k[3:0], 16'(rnd()), 2'b00);
    for (k = 0; k < 80; k++) begin
      v = rnd();
      op(v[4], v[3:0], v[31:16], (v[4] && v[6:5] != 2'b11) ? v[6:5] : 2'b00);
    end
    retain_req <= 1'b1;
    for (k = 0; k < 20 && retain_ok !== 1'b1; k++) @(negedge clk);
    chk(17'h0_0001, {16'h0000, retain_ok});
    @(posedge clk);
    retain_req <= 1'b0;
    for (k = 0; k < 16; k++) op(1'b0, k[3:0], 16'h0000, 2'b00);
    for (k = 0; k < 200 && (expq.size() > 0 || wq.size() > 0); k++) @(posedge clk);
    if (expq.size() > 0 || wq.size() > 0) err_count++;
    results();
  end
endmodule : tb
